// >>> hw/acbd_amp_control.sv
// Purpose: Control bit register and decode for a stereo amplifier
// Assumes: AXI4-Lite master; beep detector level is asynchronous
// Notes: All enables are registered; bits change only on committed writes that strobe byte 0, bridge also follows beep
// Function
// - Power-down bit 0 cuts amplifier bias
// - Power-down bit 1 leaves low power
// - All control bits reset to zero
// - Mode 0 bypasses volume, fixed gain
// - Fixed gain picked by gain source
// - Mode 1 follows five-bit volume field
// - Silence bit mutes bridge and dock
// - Silence bit 0 restores outputs
// - Beep above half supply enables bridge unless in low power
// - Beep overrides silence on bridge outputs
// - Volume all-ones is 0 dB
// - Gain source: internal or external feedback
`timescale 1ns/1ps
`include "acbd_params.svh"
`default_nettype none
module acbd_amp_control (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // AXI4-Lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Beep level detector, asynchronous
  input wire logic beepAboveHalf,
  // Amplifier enables
  output logic biasEn,
  output logic bridgeEn,
  output logic dockEn,
  output logic volumeEn,
  output logic [4:0] volumeCode,
  output logic gainExternal
);
  logic wrStb;
  logic [11:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic wrErr;
  logic [11:0] rdAddr;
  logic [31:0] rdData;
  logic rdErr;
  logic [3:0] ctrl_q;
  logic [4:0] vol_q;
  logic beepMeta_q;
  logic beepSync_q;
  logic powerDown;
  logic silence;
  logic opMode;
  logic gainSrc;
  acbd_pkg::acbd_gain_e gainSel;

  // Bus front end
  acbd_axil_slave u_bus (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wrStb(wrStb),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrErr(wrErr),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .rdErr(rdErr)
  );

  // Unmapped write addresses answer with an error
  assign wrErr = (wrAddr != `ACBD_CTRL_OFS) && (wrAddr != `ACBD_VOL_OFS);

  // commit on write
  // Only a complete AW+W pair touches the bits, so no mid-transfer glitch
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= `ACBD_CTRL_RST;
      vol_q <= `ACBD_VOL_RST;
    end else if (wrStb && wrStrb[0]) begin
      if (wrAddr == `ACBD_CTRL_OFS) begin
        ctrl_q <= wrData[3:0];
      end
      if (wrAddr == `ACBD_VOL_OFS) begin
        vol_q <= wrData[`ACBD_VOLUME_FIELD_MSB:`ACBD_VOLUME_FIELD_LSB];
      end
    end
  end

  // Beep level comes from analog; two flops before use
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      beepMeta_q <= 1'b0;
      beepSync_q <= 1'b0;
    end else begin
      beepMeta_q <= beepAboveHalf;
      beepSync_q <= beepMeta_q;
    end
  end

  // Field picks
  assign powerDown = ctrl_q[`ACBD_POWER_DOWN_BIT];
  assign silence = ctrl_q[`ACBD_SILENCE_BIT];
  assign opMode = ctrl_q[`ACBD_OPERATING_MODE_BIT];
  assign gainSrc = ctrl_q[`ACBD_GAIN_SOURCE_BIT];
  assign gainSel = gainSrc ? acbd_pkg::GAIN_EXTERNAL : acbd_pkg::GAIN_INTERNAL;

  // Registered decode of enables
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      biasEn <= 1'b0;
      bridgeEn <= 1'b0;
      dockEn <= 1'b0;
      volumeEn <= 1'b0;
      volumeCode <= `ACBD_VOL_FULL;
      gainExternal <= 1'b0;
    end else begin
      biasEn <= powerDown;
      // bridge mute, beep override
      // Bias off means nothing drives; the beep cannot wake the part
      bridgeEn <= powerDown && (!silence || beepSync_q);
      dockEn <= powerDown && !silence;
      volumeEn <= opMode;
      // fixed gain forces 0 dB code
      volumeCode <= opMode ? vol_q : `ACBD_VOL_FULL;
      gainExternal <= (gainSel == acbd_pkg::GAIN_EXTERNAL);
    end
  end

  // Read mux; status shows decoded outputs and beep
  always_comb begin
    rdData = 32'h0000_0000;
    rdErr = 1'b0;
    unique case (rdAddr)
      `ACBD_CTRL_OFS: rdData[3:0] = ctrl_q;
      `ACBD_VOL_OFS: rdData[4:0] = vol_q;
      `ACBD_STAT_OFS: rdData[5:0] = {beepSync_q, gainExternal, volumeEn,
                                     dockEn, bridgeEn, biasEn};
      default: rdErr = 1'b1;
    endcase
  end

  // A committed write walks strobe, register, then enables.
  // The sequences name the first step so each check starts there.
  sequence ctrlWrite_s;
    wrStb && wrStrb[0] && (wrAddr == `ACBD_CTRL_OFS);
  endsequence

  sequence volWrite_s;
    wrStb && wrStrb[0] && (wrAddr == `ACBD_VOL_OFS);
  endsequence

  ctrl_load_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      ctrlWrite_s |=> ctrl_q == $past(wrData[3:0]))
    else $error("control bits not loaded by write");

  vol_load_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      volWrite_s |=> vol_q ==
        $past(wrData[`ACBD_VOLUME_FIELD_MSB:`ACBD_VOLUME_FIELD_LSB]))
    else $error("volume field not loaded by write");

  // single commit
  // A second strobe would replay a stale word into the bits
  commit_once_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      wrStb |=> !wrStb)
    else $error("write committed twice");

  resp_after_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      wrStb |=> s_axi_bvalid)
    else $error("no write response after commit");

  // Bias tracks the power bit two cycles after a write
  bias_follow_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      ctrlWrite_s |-> ##2 biasEn == $past(wrData[`ACBD_POWER_DOWN_BIT], 2))
    else $error("bias enable does not follow power bit");

  sequence beepHeld_s;
    (beepSync_q && powerDown) [*2];
  endsequence

  beep_override_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      beepHeld_s |-> bridgeEn)
    else $error("beep did not open bridge while powered");

  bridge_off_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      !$past(powerDown) |-> !bridgeEn && !dockEn)
    else $error("outputs on in low power");

  mute_bridge_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      $past(silence) && !$past(beepSync_q) |-> !bridgeEn && !dockEn)
    else $error("muted outputs still enabled");

  unmute_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      $past(powerDown) && !$past(silence) |-> bridgeEn && dockEn)
    else $error("unmuted outputs not enabled");

  fixed_gain_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      !$past(opMode) |-> !volumeEn && volumeCode == 5'h1f)
    else $error("volume path active in fixed gain");

  volume_follow_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      $past(opMode) |-> volumeCode == $past(vol_q))
    else $error("volume code does not follow field");

  gain_source_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      ##1 gainExternal == $past(gainSrc))
    else $error("gain source select wrong");

  ctrl_stable_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      !$past(wrStb) |-> $stable(ctrl_q) && $stable(vol_q))
    else $error("control bits changed without a write");

  // Decode checks; each enable lags its bit by one register stage
  // bias off
  bias_off_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      !$past(powerDown) |-> !biasEn)
    else $error("bias on in low power");

  dock_mute_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      $past(silence) |-> !dockEn)
    else $error("dock outputs on while silenced");

  beep_wake_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      $past(powerDown) && $past(beepSync_q) |-> bridgeEn)
    else $error("beep did not enable bridge");

  beep_mute_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      $past(powerDown) && $past(silence) && $past(beepSync_q)
      |-> bridgeEn && !dockEn)
    else $error("beep override reached dock or missed bridge");

  // Beep lands two flops after the pin; bridge opens one edge later
  sequence beepArrive_s;
    $rose(beepSync_q) && powerDown;
  endsequence

  beep_arrive_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      beepArrive_s |=> bridgeEn)
    else $error("bridge late after beep arrived");

  mode_follow_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      ##1 volumeEn == $past(opMode))
    else $error("volume path enable does not follow mode");

  gain_internal_a:
    assert property (@(posedge clk_sys) disable iff (!rstn)
      !$past(gainSrc) |-> !gainExternal)
    else $error("external gain with internal source");
endmodule : acbd_amp_control
`default_nettype wire

// >>> hw/acbd_axil_slave.sv
// Purpose: AXI4-Lite slave front end, one write and one read at a time
// Assumes: Master keeps AXI valid/payload stable until taken
// Notes: Emits a one-cycle write strobe once both AW and W are held
`timescale 1ns/1ps
`default_nettype none
`include "acbd_params.svh"
module acbd_axil_slave (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address and data
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register side
  output logic wrStb,
  output logic [11:0] wrAddr,
  output logic [31:0] wrData,
  output logic [3:0] wrStrb,
  input wire logic wrErr,
  output logic [11:0] rdAddr,
  input wire logic [31:0] rdData,
  input wire logic rdErr
);
  logic awHeld_q;
  logic wHeld_q;

  // Accept address and data in either order, hold each until paired
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      wrAddr <= 12'h000;
      wrData <= 32'h0000_0000;
      wrStrb <= 4'h0;
      wrStb <= 1'b0;
    end else begin
      wrStb <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_awvalid && !awHeld_q && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        awHeld_q <= 1'b1;
        wrAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld_q && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
        wHeld_q <= 1'b1;
        wrData <= s_axi_wdata;
        wrStrb <= s_axi_wstrb;
      end
      // Both halves held: commit once
      if (awHeld_q && wHeld_q && !wrStb && !s_axi_bvalid) begin
        wrStb <= 1'b1;
      end
      if (wrStb) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
      end
    end
  end

  // Write response follows the commit strobe
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ACBD_RESP_OKAY;
    end else if (wrStb) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrErr ? `ACBD_RESP_SLVERR : `ACBD_RESP_OKAY;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read: take address, answer the cycle after
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ACBD_RESP_OKAY;
      rdAddr <= 12'h000;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        rdAddr <= s_axi_araddr;
      end
      if (s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdData;
        s_axi_rresp <= rdErr ? `ACBD_RESP_SLVERR : `ACBD_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : acbd_axil_slave
`default_nettype wire

// >>> hw/acbd_params.svh
// Purpose: Constants for the amplifier control bit decoder
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes: Offsets are byte addresses of aligned words
`ifndef ACBD_PARAMS_SVH
`define ACBD_PARAMS_SVH
// Register offsets
`define ACBD_CTRL_OFS 12'h000
`define ACBD_VOL_OFS 12'h004
`define ACBD_STAT_OFS 12'h008
// Control field positions
`define ACBD_POWER_DOWN_BIT 0
`define ACBD_SILENCE_BIT 1
`define ACBD_OPERATING_MODE_BIT 2
`define ACBD_GAIN_SOURCE_BIT 3
// Volume field
`define ACBD_VOLUME_FIELD_LSB 0
`define ACBD_VOLUME_FIELD_MSB 4
// Reset values
`define ACBD_CTRL_RST 4'h0
`define ACBD_VOL_RST 5'h00
`define ACBD_VOL_FULL 5'h1f
// Bus responses
`define ACBD_RESP_OKAY 2'h0
`define ACBD_RESP_SLVERR 2'h2
`endif

// >>> hw/acbd_pkg.sv
// Purpose: Types for the amplifier control bit decoder
// Assumes: Nothing beyond the params header
// Notes: Gain source encoding used by the decode output
package acbd_pkg;
  // Fixed-gain source in effect
  typedef enum logic [1:0] {
    GAIN_INTERNAL = 2'b01,
    GAIN_EXTERNAL = 2'b10
  } acbd_gain_e;
endpackage : acbd_pkg

// >>> verif/acbd_host.sv
// Purpose: Host controller model, AXI4-Lite master
// Assumes: One write and one read at most in flight
// Notes: Released address and data lines show inverted values; wstrb keeps its value
`timescale 1ns/1ps
`default_nettype none
module acbd_host (
  // Clock
  input wire logic clk_sys,
  // Write channels
  output logic [11:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // Read channels
  output logic [11:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // Idle bus from time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} <= '0;
    {araddr, arvalid, rready} <= '0;
  end
  // Write: AW and W together, each released once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    logic pa;
    logic pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw) begin
      @(posedge clk_sys);
      if (pa && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
        pa = 1'b0;
      end
      if (pw && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
        pw = 1'b0;
      end
    end
    // Response sampled at the edge that completes it
    while (!bvalid) @(posedge clk_sys);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  // Read: address held until taken, rready until data seen
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    while (!rvalid) @(posedge clk_sys);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
endmodule : acbd_host
`default_nettype wire

// >>> verif/testbench.sv
// Purpose: Self-checking bench for the amplifier control decoder
// Assumes: Outputs settle two cycles after the write response
// Notes: Beep crosses a synchroniser, so waits span four edges
`timescale 1ns/1ps
`default_nettype none
`include "acbd_params.svh"
module testbench;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic beep = 1'b0;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic biasEn, bridgeEn, dockEn, volumeEn, gainExternal;
  logic [4:0] volumeCode;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  acbd_host i_host (.clk_sys(clk_sys), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  acbd_amp_control i_dut (.clk_sys(clk_sys), .rstn(rstn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .beepAboveHalf(beep),
    .biasEn(biasEn), .bridgeEn(bridgeEn), .dockEn(dockEn),
    .volumeEn(volumeEn), .volumeCode(volumeCode),
    .gainExternal(gainExternal));
  // 200 MHz clock
  initial forever #2.5 clk_sys = ~clk_sys;
  task automatic report_and_stop;
    if (n_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // Hang guard, far above the 120 or so cycles needed
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Write with response check, then let outputs settle
  task automatic wchk(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
    logic [1:0] r;
    i_host.wr(a, d, s, r);
    check({30'h0000_0000, r}, {30'h0000_0000, er});
    repeat (2) @(posedge clk_sys);
  endtask : wchk
  task automatic rchk(input logic [11:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    i_host.rd(a, d, r);
    check(d, ed);
    check({30'h0000_0000, r}, {30'h0000_0000, er});
  endtask : rchk
  // Outputs packed as {code, gainExt, volEn, dock, bridge, bias}
  task automatic outs(input logic [9:0] e);
    check({22'h00_0000, volumeCode, gainExternal, volumeEn, dockEn,
           bridgeEn, biasEn}, {22'h00_0000, e});
  endtask : outs
  task automatic t_reset;
    outs({5'h1f, 5'h00});
    rchk(`ACBD_CTRL_OFS, 32'h0000_0000, `ACBD_RESP_OKAY);
  endtask : t_reset
  task automatic t_power;
    wchk(`ACBD_CTRL_OFS, 32'h0000_0001, 4'hf, `ACBD_RESP_OKAY);
    outs({5'h1f, 5'h07});
    rchk(`ACBD_STAT_OFS, 32'h0000_0007, `ACBD_RESP_OKAY);
    wchk(`ACBD_CTRL_OFS, 32'h0000_0000, 4'hf, `ACBD_RESP_OKAY);
    outs({5'h1f, 5'h00});
  endtask : t_power
  task automatic t_silence;
    wchk(`ACBD_CTRL_OFS, 32'h0000_0003, 4'hf, `ACBD_RESP_OKAY);
    outs({5'h1f, 5'h01});
    @(posedge clk_sys);
    beep <= 1'b1;
    repeat (4) @(posedge clk_sys);
    outs({5'h1f, 5'h03});
    beep <= 1'b0;
    repeat (4) @(posedge clk_sys);
    outs({5'h1f, 5'h01});
    wchk(`ACBD_CTRL_OFS, 32'h0000_0001, 4'hf, `ACBD_RESP_OKAY);
    outs({5'h1f, 5'h07});
  endtask : t_silence
  task automatic t_mode;
    wchk(`ACBD_VOL_OFS, 32'h0000_000a, 4'hf, `ACBD_RESP_OKAY);
    outs({5'h1f, 5'h07});
    wchk(`ACBD_CTRL_OFS, 32'h0000_0005, 4'hf, `ACBD_RESP_OKAY);
    outs({5'h0a, 5'h0f});
    wchk(`ACBD_VOL_OFS, 32'h0000_001f, 4'hf, `ACBD_RESP_OKAY);
    outs({5'h1f, 5'h0f});
    rchk(`ACBD_VOL_OFS, 32'h0000_001f, `ACBD_RESP_OKAY);
    wchk(`ACBD_CTRL_OFS, 32'h0000_0009, 4'hf, `ACBD_RESP_OKAY);
    outs({5'h1f, 5'h17});
    wchk(`ACBD_CTRL_OFS, 32'h0000_0001, 4'hf, `ACBD_RESP_OKAY);
    outs({5'h1f, 5'h07});
  endtask : t_mode
  task automatic t_bus;
    wchk(`ACBD_CTRL_OFS, 32'h0000_0000, 4'he, `ACBD_RESP_OKAY);
    outs({5'h1f, 5'h07});
    wchk(12'h00c, 32'h0000_0000, 4'hf, `ACBD_RESP_SLVERR);
    wchk(`ACBD_STAT_OFS, 32'h0000_0000, 4'hf, `ACBD_RESP_SLVERR);
    outs({5'h1f, 5'h07});
    rchk(12'h00c, 32'h0000_0000, `ACBD_RESP_SLVERR);
  endtask : t_bus
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_power();
    t_silence();
    t_mode();
    t_bus();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
